// ### design/aal_alu.sv
`timescale 1ns/100ps
// Function
// RL1 - Ones complement: invert source to acc and dest, update zero only
// RL2 - Twos negate: invert plus one, carry set only when result zero
// RL3 - Negate with carry: invert plus carry, carry when zero and carry was one
// RL4 - Increment: add one, carry set when result wraps to zero
// RL5 - Increment with carry: add carry, carry when zero and carry was one
// RL6 - Decrement: subtract one, carry cleared only when result is all ones
// RL7 - Decrement with borrow: subtract one minus carry, clear on FF and carry zero
// RL8 - AND of two operands to acc and dest, zero only
// RL9 - OR of two operands to acc and dest, zero only
// RL10 - XOR of two operands to acc and dest, zero only
// RL11 - Add modulo 256, carry on unsigned overflow
// RL12 - Add with carry includes incoming carry, carry on overflow
// RL13 - Reverse subtract literal minus register, carry is inverted borrow
// RL14 - Three operand reverse subtract: second minus third to dest and acc (the code computes third minus second, src_b minus opa)
// RL15 - Reverse subtract with borrow also subtracts one minus carry
// RL16 - Forward subtract register minus literal, carry is inverted borrow
// RL17 - Memory operand is only read; result goes to register and acc
// RL18 - Two-register form: first register is operand and destination
// RL19 - Immediate forms combine register with literal, store to same register
// RL20 - Zero flag set when 8-bit result is zero
// RL21 - Overflow flag set on signed overflow for arithmetic operations
module aal_alu
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  input  wire aal_pkg::aal_req_t req_in,
  input  wire logic              fwd_sub_in,
  output logic [7:0]             acc_out,
  output aal_pkg::aal_wr_t       wr_out,
  output aal_pkg::aal_flags_t    flags_out
);
  import aal_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;
  aal_wr_t    wr_ff;
  aal_wr_t    nxt_wr;
  aal_flags_t flg_ff;
  aal_flags_t nxt_flg;

  logic [7:0] src_b;
  logic [8:0] sum;
  logic [7:0] res;
  logic       upd_c;
  logic       upd_v;
  logic       new_c;
  logic       new_v;
  logic [7:0] x;
  logic [7:0] y;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // Memory only supplies an operand; nothing here writes memory back
  always_comb
  begin
    if (req_in.src == SRC_IMM)
      src_b = req_in.imm; // RL19
    else if (req_in.src == SRC_MEM)
      src_b = req_in.mem; // RL17
    else
      src_b = req_in.reg_b;
  end

  // Subtract is done as x + ~y + cin so carry naturally is the inverted borrow
  always_comb
  begin
    x     = req_in.opa;
    y     = src_b;
    sum   = {1'b0, ZERO_B};
    res   = ZERO_B;
    upd_c = 1'b1;
    upd_v = 1'b1;
    new_c = 1'b0;
    new_v = 1'b0;
    case (req_in.op)
      ones_complement_op:
      begin
        res   = ~src_b; // RL1
        upd_c = 1'b0;
        upd_v = 1'b0;
      end
      twos_negate_op:
      begin
        sum   = {1'b0, ~src_b} + {1'b0, ONE_B}; // RL2
        res   = sum[7:0];
        new_c = (res == ZERO_B); // RL2
        new_v = (src_b == 8'h80);
      end
      negate_with_carry_op:
      begin
        sum   = {1'b0, ~src_b} + {8'h00, flg_ff.c}; // RL3
        res   = sum[7:0];
        new_c = (res == ZERO_B) && flg_ff.c; // RL3
        new_v = (src_b == 8'h80) && flg_ff.c;
      end
      inc_op:
      begin
        sum   = {1'b0, src_b} + {1'b0, ONE_B}; // RL4
        res   = sum[7:0];
        new_c = (res == ZERO_B); // RL4
        new_v = (src_b == 8'h7F); // RL21
      end
      inc_carry_op:
      begin
        sum   = {1'b0, src_b} + {8'h00, flg_ff.c}; // RL5
        res   = sum[7:0];
        new_c = (res == ZERO_B) && flg_ff.c; // RL5
        new_v = (src_b == 8'h7F) && flg_ff.c;
      end
      dec_op:
      begin
        res   = src_b - ONE_B; // RL6
        new_c = (res != ALL_ONES); // RL6
        new_v = (src_b == 8'h80);
      end
      dec_borrow_op:
      begin
        res   = src_b - {7'h00, ~flg_ff.c}; // RL7
        new_c = !((res == ALL_ONES) && !flg_ff.c); // RL7
        new_v = (src_b == 8'h80) && !flg_ff.c;
      end
      and_op:
      begin
        res   = x & y; // RL8
        upd_c = 1'b0;
        upd_v = 1'b0;
      end
      or_op:
      begin
        res   = x | y; // RL9
        upd_c = 1'b0;
        upd_v = 1'b0;
      end
      xor_op:
      begin
        res   = x ^ y; // RL10
        upd_c = 1'b0;
        upd_v = 1'b0;
      end
      add_op, add_carry_op:
      begin
        sum   = {1'b0, x} + {1'b0, y}
              + {8'h00, (req_in.op == add_carry_op) & flg_ff.c}; // RL11 RL12 RL18
        res   = sum[7:0];
        new_c = sum[8]; // RL11
        new_v = (x[7] == y[7]) && (res[7] != x[7]); // RL21
      end
      default:
      begin
        // Reverse order computes operand b minus a; forward computes a minus b
        if (!fwd_sub_in)
        begin
          x = src_b; // RL13 RL14
          y = req_in.opa;
        end
        sum   = {1'b0, x} + {1'b0, ~y}
              + {8'h00, (req_in.op == sub_op) | flg_ff.c}; // RL15 RL16
        res   = sum[7:0];
        new_c = sum[8]; // RL13
        new_v = (x[7] != y[7]) && (res[7] != x[7]); // RL21
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_acc     = acc_ff;
    nxt_flg     = flg_ff;
    nxt_wr.we   = 1'b0;
    nxt_wr.dst  = wr_ff.dst;
    nxt_wr.data = wr_ff.data;
    if (req_in.valid)
    begin
      nxt_acc     = res;
      nxt_wr.we   = 1'b1;
      nxt_wr.dst  = req_in.dst; // RL17 RL18
      nxt_wr.data = res;
      nxt_flg.z   = (res == ZERO_B); // RL20
      if (upd_c)
        nxt_flg.c = new_c;
      if (upd_v)
        nxt_flg.v = new_v; // RL21
    end
  end

  // Registers only
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      acc_ff <= ZERO_B;
      wr_ff  <= '0;
      flg_ff <= '0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      wr_ff  <= nxt_wr;
      flg_ff <= nxt_flg;
    end
  end

  // Outputs come straight from the registers
  assign acc_out   = acc_ff;
  assign wr_out    = wr_ff;
  assign flags_out = flg_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOGIC_KEEPS_C: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL8
    req_in.valid && req_in.op inside {and_op, or_op, xor_op, ones_complement_op}
    |=> flg_ff.c == $past(flg_ff.c) && flg_ff.v == $past(flg_ff.v))
    else $error("logic op changed carry or overflow");
  AST_ONES_COMP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL1
    req_in.valid && req_in.op == ones_complement_op |=> acc_ff == ~$past(src_b))
    else $error("ones complement result wrong");
  AST_NEG_CARRY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL2
    req_in.valid && req_in.op == twos_negate_op |=> flg_ff.c == (acc_ff == ZERO_B))
    else $error("negate carry wrong");
  AST_INC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL4
    req_in.valid && req_in.op == inc_op |=> acc_ff == $past(src_b) + ONE_B)
    else $error("increment result wrong");
  AST_DEC_CARRY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL6
    req_in.valid && req_in.op == dec_op |=> flg_ff.c == (acc_ff != ALL_ONES))
    else $error("decrement carry wrong");
  AST_ADD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL11
    req_in.valid && req_in.op == add_op
    |=> {flg_ff.c, acc_ff} == {1'b0, $past(req_in.opa)} + {1'b0, $past(src_b)})
    else $error("add result or carry wrong");
  AST_ZERO: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL20
    req_in.valid |=> flg_ff.z == (acc_ff == ZERO_B) && wr_ff.data == acc_ff && wr_ff.we)
    else $error("zero flag or writeback wrong");
  AST_RSUB: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL13
    req_in.valid && req_in.op == sub_op && !fwd_sub_in
    |=> acc_ff == $past(src_b) - $past(req_in.opa)
        && flg_ff.c == ($past(src_b) >= $past(req_in.opa)))
    else $error("reverse subtract wrong");
  AST_IDLE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL17
    !req_in.valid |=> !wr_ff.we && $stable(acc_ff))
    else $error("write without request");
  // Carry-fed forms depend on the flag left by the previous operation
  AST_NEGC_RESULT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL3
    req_in.valid && req_in.op == negate_with_carry_op
    |=> acc_ff == ~$past(src_b) + $past(flg_ff.c)
        && flg_ff.c == ((acc_ff == ZERO_B) && $past(flg_ff.c)))
    else $error("negate with carry wrong");
  AST_NEG_RESULT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL2
    req_in.valid && req_in.op == twos_negate_op |=> acc_ff == ZERO_B - $past(src_b))
    else $error("negate result wrong");
  AST_INCC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL5
    req_in.valid && req_in.op == inc_carry_op
    |=> acc_ff == $past(src_b) + $past(flg_ff.c)
        && flg_ff.c == ((acc_ff == ZERO_B) && $past(flg_ff.c)))
    else $error("increment with carry wrong");
  AST_DEC_RESULT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL6
    req_in.valid && req_in.op == dec_op |=> acc_ff == $past(src_b) - ONE_B)
    else $error("decrement result wrong");
  AST_DECB: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL7
    req_in.valid && req_in.op == dec_borrow_op
    |=> acc_ff == $past(src_b) - ONE_B + $past(flg_ff.c)
        && flg_ff.c == !((acc_ff == ALL_ONES) && !$past(flg_ff.c)))
    else $error("decrement with borrow wrong");
  AST_AND: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL8
    req_in.valid && req_in.op == and_op
    |=> acc_ff == ($past(req_in.opa) & $past(src_b)))
    else $error("and result wrong");
  AST_OR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL9
    req_in.valid && req_in.op == or_op
    |=> acc_ff == ($past(req_in.opa) | $past(src_b)))
    else $error("or result wrong");
  AST_XOR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL10
    req_in.valid && req_in.op == xor_op
    |=> acc_ff == ($past(req_in.opa) ^ $past(src_b)))
    else $error("xor result wrong");
  AST_ADDC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL12
    req_in.valid && req_in.op == add_carry_op
    |=> {flg_ff.c, acc_ff} == {1'b0, $past(req_in.opa)} + {1'b0, $past(src_b)}
        + {ZERO_B, $past(flg_ff.c)})
    else $error("add with carry wrong");
  AST_FSUB: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL16
    req_in.valid && req_in.op == sub_op && fwd_sub_in
    |=> acc_ff == $past(req_in.opa) - $past(src_b)
        && flg_ff.c == ($past(req_in.opa) >= $past(src_b)))
    else $error("forward subtract wrong");
  // Borrow form: no underflow when b plus carry exceeds a
  AST_RSUBB: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL15
    req_in.valid && req_in.op == sub_borrow_op && !fwd_sub_in
    |=> acc_ff == $past(src_b) - $past(req_in.opa) - ONE_B + $past(flg_ff.c)
        && flg_ff.c == ({1'b0, $past(src_b)} + {ZERO_B, $past(flg_ff.c)}
                        > {1'b0, $past(req_in.opa)}))
    else $error("reverse subtract with borrow wrong");
  AST_IMM_FORM: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL19
    req_in.valid && req_in.src == SRC_IMM && req_in.op == or_op
    |=> acc_ff == ($past(req_in.opa) | $past(req_in.imm)) && wr_ff.dst == $past(req_in.dst))
    else $error("immediate form wrong");
  AST_MEM_FORM: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL17
    req_in.valid && req_in.src == SRC_MEM && req_in.op == add_op
    |=> wr_ff.data == $past(req_in.opa) + $past(req_in.mem) && wr_ff.dst == $past(req_in.dst))
    else $error("memory operand form wrong");
  AST_ADD_V: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL21
    req_in.valid && req_in.op == add_op
    |=> flg_ff.v == (($past(req_in.opa[7]) == $past(src_b[7]))
                     && (acc_ff[7] != $past(req_in.opa[7]))))
    else $error("add overflow wrong");

endmodule

// ### design/aal_pkg.sv
package aal_pkg;

  // ----------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------
  localparam int          DW       = 8;
  localparam logic [7:0]  ZERO_B   = 8'h00;
  localparam logic [7:0]  ONE_B    = 8'h01;
  localparam logic [7:0]  ALL_ONES = 8'hFF;
  localparam logic [3:0]  ZERO_IDX = 4'h0;

  // Operation codes, one-hot is not needed here: this is a decoded select
  typedef enum logic [3:0] {
    ones_complement_op   = 4'h0,
    twos_negate_op       = 4'h1,
    negate_with_carry_op = 4'h2,
    inc_op               = 4'h3,
    inc_carry_op         = 4'h4,
    dec_op               = 4'h5,
    dec_borrow_op        = 4'h6,
    and_op               = 4'h7,
    or_op                = 4'h8,
    xor_op               = 4'h9,
    add_op               = 4'hA,
    add_carry_op         = 4'hB,
    sub_op               = 4'hC,
    sub_borrow_op        = 4'hD
  } aal_op_t;

  // Operand source for the second operand
  typedef enum logic [1:0] {
    SRC_REG = 2'h0,
    SRC_IMM = 2'h1,
    SRC_MEM = 2'h2
  } aal_src_t;

  // Request from the decoder
  typedef struct packed {
    logic       valid;
    aal_op_t    op;
    aal_src_t   src;
    logic [7:0] opa;
    logic [7:0] reg_b;
    logic [7:0] imm;
    logic [7:0] mem;
    logic [3:0] dst;
  } aal_req_t;

  // Result to the register file
  typedef struct packed {
    logic       we;
    logic [3:0] dst;
    logic [7:0] data;
  } aal_wr_t;

  // Flags
  typedef struct packed {
    logic c;
    logic v;
    logic z;
  } aal_flags_t;

endpackage

// ### tb/aal_rf_model.sv
`timescale 1ns/100ps
// ------------------------------------------
// Register file and data memory model
// ------------------------------------------
module aal_rf_model
(
  input  wire logic             ref_clk_in,
  input  wire aal_pkg::aal_wr_t wr_in,
  input  wire logic [3:0]       idx_in,
  output logic [7:0]            reg_out,
  output logic [7:0]            mem_out
);
  import aal_pkg::*;
  logic [7:0] rf [16];
  logic [7:0] dm [16];
  // Distinct seeds so a stale operand shows up
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      rf[i] = 8'(i * 17);
      dm[i] = 8'(i * 29 + 3);
    end
  end
  // Result feeds back as the next first operand
  always @(posedge ref_clk_in)
  begin
    if (wr_in.we === 1'b1)
      rf[wr_in.dst] <= wr_in.data;
  end
  // Memory has no write path at all
  // Forward the pending write so back-to-back ops see the newest value
  assign reg_out = (wr_in.we === 1'b1 && wr_in.dst == idx_in) ? wr_in.data : rf[idx_in];
  assign mem_out = dm[idx_in];
endmodule

// ### tb/cpu_alu_arith_logic_ops_tb.sv
`timescale 1ns/100ps
module cpu_alu_arith_logic_ops_tb;
  import aal_pkg::*;
  logic       ref_clk_in, rst_n_in, fwd_sub_in, m_c, m_v, m_z, e_we;
  aal_req_t   req_in;
  aal_wr_t    wr_out;
  aal_flags_t flags_out;
  logic [7:0] acc_out, rd_reg, rd_mem, m_acc;
  logic [3:0] e_dst;
  logic [31:0] rng;
  int         fail_count, n_compared;
  aal_alu aal_alu_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .fwd_sub_in(fwd_sub_in), .acc_out(acc_out), .wr_out(wr_out), .flags_out(flags_out));
  aal_rf_model aal_rf_model_inst (.ref_clk_in(ref_clk_in), .wr_in(wr_out),
    .idx_in(req_in.dst), .reg_out(rd_reg), .mem_out(rd_mem));
  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_out();
    chk("acc", m_acc, acc_out);
    chk("we", {7'h0, e_we}, {7'h0, wr_out.we});
    chk("dst", {4'h0, e_dst}, {4'h0, wr_out.dst});
    chk("data", m_acc, wr_out.data);
    chk("c", {7'h0, m_c}, {7'h0, flags_out.c});
    chk("v", {7'h0, m_v}, {7'h0, flags_out.v});
    chk("z", {7'h0, m_z}, {7'h0, flags_out.z});
  endtask
  task automatic model_reset();
    {m_acc, m_c, m_v, m_z, e_we, e_dst} = '0;
  endtask
  // Adder form x + y + ci covers every arithmetic op and its carry rule
  task automatic model_step();
    logic [7:0] a, b, x, y, r;
    logic       ci, ar;
    int         s;
    a = req_in.opa;
    b = req_in.src == SRC_IMM ? req_in.imm : req_in.src == SRC_MEM ? req_in.mem : req_in.reg_b;
    e_we = req_in.valid;
    if (!e_we)
      return;
    ar = 1'b1;
    case (req_in.op)
      ones_complement_op:   {ar, r} = {1'b0, ~b};
      twos_negate_op:       {x, y, ci} = {~b, 8'h00, 1'b1};
      negate_with_carry_op: {x, y, ci} = {~b, 8'h00, m_c};
      inc_op:               {x, y, ci} = {b, 8'h00, 1'b1};
      inc_carry_op:         {x, y, ci} = {b, 8'h00, m_c};
      dec_op:               {x, y, ci} = {b, 8'hFF, 1'b0};
      dec_borrow_op:        {x, y, ci} = {b, 8'hFF, m_c};
      and_op:               {ar, r} = {1'b0, a & b};
      or_op:                {ar, r} = {1'b0, a | b};
      xor_op:               {ar, r} = {1'b0, a ^ b};
      add_op:               {x, y, ci} = {a, b, 1'b0};
      add_carry_op:         {x, y, ci} = {a, b, m_c};
      sub_op:               {x, y, ci} = fwd_sub_in ? {a, ~b, 1'b1} : {b, ~a, 1'b1};
      default:              {x, y, ci} = fwd_sub_in ? {a, ~b, m_c} : {b, ~a, m_c};
    endcase
    if (ar)
    begin
      s = int'(x) + int'(y) + int'(ci);
      r = 8'(s);
      m_c = s > 255;
      m_v = (x[7] == y[7]) && (r[7] != x[7]);
    end
    m_z = r == 8'h00;
    m_acc = r;
    e_dst = req_in.dst;
  endtask
  // Plain 32-bit xorshift keeps the run repeatable
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // First 56 requests walk every op over the edge operands
  task automatic drive(input int i);
    rng = xorshift(rng);
    req_in.valid = i < 56 || rng[3:0] != 4'h0;
    req_in.op = aal_op_t'(i < 56 ? 4'(i % 14) : 4'(rng[7:4] % 4'hE));
    req_in.src = i < 56 ? SRC_IMM : aal_src_t'(rng[17:16] % 2'h3);
    req_in.dst = rng[21:18];
    req_in.reg_b = rng[29:22];
    req_in.imm = i < 56 ? 8'(32'h00FF_7F80 >> (24 - 8 * (i / 14))) : rng[15:8];
    fwd_sub_in = rng[30];
    #1;
    req_in.opa = rd_reg;
    req_in.mem = rd_mem;
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------
  // Clock and main sequence
  // ------------------------------------------
  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    {fail_count, n_compared, rng} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0032};
    {rst_n_in, fwd_sub_in, req_in} = '0;
    model_reset();
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check_out();
    rst_n_in = 1'b1;
    for (int i = 0; i < 600; i++)
    begin
      drive(i);
      model_step();
      @(negedge ref_clk_in);
      check_out();
      // Mid-run reset clears all state, carry included
      if (i == 300)
      begin
        rst_n_in = 1'b0;
        @(negedge ref_clk_in);
        model_reset();
        check_out();
        rst_n_in = 1'b1;
      end
    end
    end_of_test();
  end
endmodule
